//--- rtl/sapc_control.sv
// Control, approximation and output logic of the sampling converter
`timescale 1ns/1ps
`default_nettype none
`include "sapc_map.svh"
module sapc_control #(
    parameter int DATA_WIDTH  = `SAPC_DATA_WIDTH,
    parameter int CONV_CYCLES = `SAPC_CONV_CYCLES
) (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire sapc_pkg::sapc_ctrl_t ctrl,
    input  wire logic               compareHigh,
    output logic                    sampleHold,
    output logic [DATA_WIDTH-1:0]   trialCode,
    output logic                    busyN,
    output sapc_pkg::sapc_bus_t     bus
);
    import sapc_pkg::*;

    initial begin
        // Byte swap and bus struct are fixed at sixteen lines
        if (DATA_WIDTH != 16) begin
            $error("sapc_control: data width must be 16");
        end
        // One cycle per bit decision at least
        if (CONV_CYCLES < DATA_WIDTH) begin
            $error("sapc_control: too few conversion cycles");
        end
    end

    localparam int CW = $clog2(CONV_CYCLES + 1);
    localparam int BW = $clog2(DATA_WIDTH);
    localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYCLES - 1);
    // Cycles per bit decision, rest spent before the first bit
    localparam int BIT_CYCLES = CONV_CYCLES / DATA_WIDTH;
    localparam int LEAD = CONV_CYCLES - BIT_CYCLES * DATA_WIDTH;

    // Internal OR of select and read/convert
    logic startLine;
    logic startLine_q;
    logic readLine;
    logic startEdge;
    assign startLine = ctrl.selectN | ctrl.readConvertN;
    assign readLine  = !ctrl.selectN && ctrl.readConvertN;
    assign startEdge = startLine_q && !startLine; // [R01] [R03]

    sapc_state_t state_q;
    sapc_state_t state_d;
    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    logic [BW-1:0] bitIdx_q;
    logic [BW-1:0] bitIdx_d;
    logic [DATA_WIDTH-1:0] sar_q;
    logic [DATA_WIDTH-1:0] sar_d;
    logic [DATA_WIDTH-1:0] latch_q;
    logic [DATA_WIDTH-1:0] latch_d;
    logic bitStrobe;

    assign bitStrobe = (count_q >= CW'(LEAD)) &&
        (((count_q - CW'(LEAD)) % CW'(BIT_CYCLES)) == CW'(BIT_CYCLES - 1));

    always_comb begin
        state_d  = state_q;
        count_d  = count_q;
        bitIdx_d = bitIdx_q;
        sar_d    = sar_q;
        latch_d  = latch_q;
        case (state_q)
            SAPC_IDLE: begin
                if (startEdge) begin // [R01] [R03]
                    state_d  = SAPC_CONV;
                    count_d  = '0;
                    bitIdx_d = BW'(DATA_WIDTH - 1);
                    sar_d    = '0; // [R11]
                end
            end
            SAPC_CONV: begin
                // Start edges are not looked at here [R12]
                count_d = count_q + CW'(1);
                if (bitStrobe) begin
                    sar_d[bitIdx_q] = compareHigh; // [R13]
                    bitIdx_d = bitIdx_q - BW'(1);
                end
                if (count_q == CONV_LAST) begin
                    state_d = SAPC_DONE;
                end
            end
            SAPC_DONE: begin
                latch_d = sar_q; // [R14] [R16]
                state_d = SAPC_IDLE;
            end
            default: begin
                state_d = SAPC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q     <= SAPC_IDLE; // [R19]
            count_q     <= '0;
            bitIdx_q    <= '0;
            sar_q       <= '0;
            latch_q     <= `SAPC_RESULT_RESET;
            startLine_q <= 1'b1;
        end else begin
            state_q     <= state_d;
            count_q     <= count_d;
            bitIdx_q    <= bitIdx_d;
            sar_q       <= sar_d;
            latch_q     <= latch_d;
            startLine_q <= startLine;
        end
    end

    // Trial word: decided bits, current bit set, lower bits clear
    always_comb begin
        trialCode = sar_q;
        if (state_q == SAPC_CONV) begin
            trialCode[bitIdx_q] = 1'b1;
        end
    end

    assign sampleHold = (state_q != SAPC_IDLE);
    assign busyN = (state_q == SAPC_IDLE); // [R07] [R08]

    // Bus enabled by the read condition, which the rising or select edge opens
    logic [DATA_WIDTH-1:0] ordered;
    assign ordered = ctrl.byteSwap ? {latch_q[7:0], latch_q[15:8]} : latch_q; // [R06]
    assign bus.dataOut = ordered;
    assign bus.dataOe  = {DATA_WIDTH{readLine}}; // [R02] [R04] [R05]

    property p_start;
        @(posedge clk) disable iff (rst)
        (startEdge && state_q == SAPC_IDLE) |=> (state_q == SAPC_CONV && sar_q == '0);
    endproperty
    a_start: assert property (p_start) else $error("start edge did not begin conversion"); // [R01]

    property p_busy_len;
        @(posedge clk) disable iff (rst)
        $fell(busyN) |-> !busyN [*8];
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy too short"); // [R07]

    property p_busy_end;
        @(posedge clk) disable iff (rst)
        $fell(busyN) |-> ##[20:30] busyN;
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("conversion did not end in time"); // [R17]

    property p_valid;
        @(posedge clk) disable iff (rst)
        $rose(busyN) |-> (latch_q == $past(sar_q));
    endproperty
    a_valid: assert property (p_valid) else $error("result not valid at busy rise"); // [R08]

    property p_latch_hold;
        @(posedge clk) disable iff (rst)
        (state_q == SAPC_CONV) |=> $stable(latch_q);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch changed mid conversion"); // [R14]

    property p_norestart;
        @(posedge clk) disable iff (rst)
        (state_q == SAPC_CONV && count_q != CONV_LAST) |=> (state_q == SAPC_CONV && count_q == $past(count_q) + CW'(1));
    endproperty
    a_norestart: assert property (p_norestart) else $error("conversion restarted"); // [R12]

    property p_hiz;
        @(posedge clk) disable iff (rst)
        (ctrl.selectN || !ctrl.readConvertN) |-> (bus.dataOe == '0);
    endproperty
    a_hiz: assert property (p_hiz) else $error("bus driven while deselected"); // [R05]

    property p_swap;
        @(posedge clk) disable iff (rst)
        ctrl.byteSwap |-> (bus.dataOut[7:0] == latch_q[15:8]);
    endproperty
    a_swap: assert property (p_swap) else $error("byte swap wrong"); // [R06]

    property p_msb_first;
        @(posedge clk) disable iff (rst)
        (state_q == SAPC_CONV && bitStrobe) |=> (bitIdx_q == $past(bitIdx_q) - BW'(1));
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("bit order wrong"); // [R13]

    // Start and busy behaviour

    property p_busy_start;
        @(posedge clk) disable iff (rst)
        (startEdge && state_q == SAPC_IDLE) |=> !busyN;
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy did not fall on start"); // [R07]

    property p_busy_conv;
        @(posedge clk) disable iff (rst)
        (state_q == SAPC_CONV) |-> !busyN;
    endproperty
    a_busy_conv: assert property (p_busy_conv) else $error("busy high during conversion"); // [R07]

    property p_hold_busy;
        @(posedge clk) disable iff (rst)
        !busyN |-> sampleHold;
    endproperty
    a_hold_busy: assert property (p_hold_busy) else $error("sampler not in hold while busy"); // [R01]

    property p_ignore;
        @(posedge clk) disable iff (rst)
        (startEdge && state_q == SAPC_CONV) |=> (state_q != SAPC_IDLE);
    endproperty
    a_ignore: assert property (p_ignore) else $error("start edge disturbed conversion"); // [R12]

    property p_idle_still;
        @(posedge clk) disable iff (rst)
        (state_q == SAPC_IDLE && !startEdge) |=> (state_q == SAPC_IDLE);
    endproperty
    a_idle_still: assert property (p_idle_still) else $error("conversion without start edge"); // [R19]

    property p_sample_idle;
        @(posedge clk) disable iff (rst)
        (state_q == SAPC_IDLE) |-> !sampleHold;
    endproperty
    a_sample_idle: assert property (p_sample_idle) else $error("sampler held while idle"); // [R19]

    // Conversion sequencing

    property p_seq_init;
        @(posedge clk) disable iff (rst)
        (startEdge && state_q == SAPC_IDLE) |=> (count_q == '0 && bitIdx_q == BW'(DATA_WIDTH - 1));
    endproperty
    a_seq_init: assert property (p_seq_init) else $error("sequence not started at top bit"); // [R13]

    property p_lead_quiet;
        @(posedge clk) disable iff (rst)
        (state_q == SAPC_CONV && count_q < CW'(LEAD)) |=> $stable(sar_q);
    endproperty
    a_lead_quiet: assert property (p_lead_quiet) else $error("bit decided before lead end"); // [R11]

    property p_trial_bit;
        @(posedge clk) disable iff (rst)
        (state_q == SAPC_CONV) |-> trialCode[bitIdx_q];
    endproperty
    a_trial_bit: assert property (p_trial_bit) else $error("trial bit not set"); // [R13]

    property p_conv_end;
        @(posedge clk) disable iff (rst)
        (state_q == SAPC_CONV && count_q == CONV_LAST) |=> (state_q == SAPC_DONE);
    endproperty
    a_conv_end: assert property (p_conv_end) else $error("conversion did not finish"); // [R17]

    property p_bit_done;
        @(posedge clk) disable iff (rst)
        (state_q == SAPC_DONE) |-> (bitIdx_q == BW'(DATA_WIDTH - 1));
    endproperty
    a_bit_done: assert property (p_bit_done) else $error("not every bit decided"); // [R13]

    // Output latch and bus

    property p_latch_load;
        @(posedge clk) disable iff (rst)
        (state_q == SAPC_DONE) |=> (latch_q == $past(sar_q));
    endproperty
    a_latch_load: assert property (p_latch_load) else $error("result not loaded"); // [R14]

    property p_sar_keep;
        @(posedge clk) disable iff (rst)
        (state_q == SAPC_DONE) |=> $stable(sar_q);
    endproperty
    a_sar_keep: assert property (p_sar_keep) else $error("register changed at load"); // [R14]

    property p_done_once;
        @(posedge clk) disable iff (rst)
        (state_q == SAPC_DONE) |=> (state_q == SAPC_IDLE);
    endproperty
    a_done_once: assert property (p_done_once) else $error("busy not released after load"); // [R08]

    property p_latch_idle;
        @(posedge clk) disable iff (rst)
        (state_q == SAPC_IDLE) |=> $stable(latch_q);
    endproperty
    a_latch_idle: assert property (p_latch_idle) else $error("latch changed while idle"); // [R08]

    property p_read_en;
        @(posedge clk) disable iff (rst)
        (!ctrl.selectN && ctrl.readConvertN) |-> (bus.dataOe == '1);
    endproperty
    a_read_en: assert property (p_read_en) else $error("bus not enabled for read"); // [R02] [R04]

    property p_straight;
        @(posedge clk) disable iff (rst)
        !ctrl.byteSwap |-> (bus.dataOut == latch_q);
    endproperty
    a_straight: assert property (p_straight) else $error("word order wrong"); // [R06]

    property p_swap_hi;
        @(posedge clk) disable iff (rst)
        ctrl.byteSwap |-> (bus.dataOut[15:8] == latch_q[7:0]);
    endproperty
    a_swap_hi: assert property (p_swap_hi) else $error("upper swapped byte wrong"); // [R06]

    // Scenario covers

    c_retry: cover property (@(posedge clk) disable iff (rst) startEdge && state_q == SAPC_CONV);
    c_conv: cover property (@(posedge clk) disable iff (rst) $rose(busyN));
    c_read: cover property (@(posedge clk) disable iff (rst) $rose(readLine));
    c_swap: cover property (@(posedge clk) disable iff (rst) readLine && ctrl.byteSwap);
endmodule
`default_nettype wire

//--- shared/sapc_map.svh
// Constants of the APPROXIMATION_REGISTER converter parallel-port control block
// Behaviour
// R01: Select low and read/convert falling starts hold and a new conversion.
// R02: Select low and read/convert rising drives stored result onto data outputs.
// R03: Select ORed with read/convert; select falling while read/convert low starts conversion.
// R04: Select falling while read/convert high enables the result onto the bus.
// R05: Data lines float whenever select is high or read/convert is low.
// R06: Byte select low gives normal order; high swaps upper and lower bytes.
// R07: Busy is low throughout a conversion and high otherwise.
// R08: The new result is valid when busy returns high.
// R09: Host keeps select or read/convert high when busy rises, else reconversion; here start needs a falling edge, so lines held low do not reconvert.
// R10: Host returns read/convert high within 1 us after start.
// R11: Approximation register cleared at the start of each conversion.
// R12: Start edges during a conversion are ignored.
// R13: Bits decided in sequence from most significant down to least.
// R14: At completion the approximation register is copied to the output latches.
// R15: Host allows at least 1.5 us acquisition between conversions.
// R16: Result is presented in two's complement format.
// R17: Internal clock completes a conversion in about 2.3 us.
// R18: Host holds the start input low for at least 40 ns.
// R19: After reset the block idles with busy high and nothing running.
`ifndef SAPC_MAP_SVH
`define SAPC_MAP_SVH
`define SAPC_CLK_PERIOD_NS 100
`define SAPC_CONV_TIME_NS 2300
`define SAPC_CONV_CYCLES (`SAPC_CONV_TIME_NS / `SAPC_CLK_PERIOD_NS)
`define SAPC_RESULT_RESET 16'h0000
`define SAPC_DATA_WIDTH 16
`endif

//--- shared/sapc_pkg.sv
// Types of the APPROXIMATION_REGISTER converter parallel-port control block
package sapc_pkg;
    typedef enum logic [2:0] {
        SAPC_IDLE = 3'b001,
        SAPC_CONV = 3'b010,
        SAPC_DONE = 3'b100
    } sapc_state_t;

    typedef struct packed {
        logic selectN;
        logic readConvertN;
        logic byteSwap;
    } sapc_ctrl_t;

    typedef struct packed {
        logic [15:0] dataOut;
        logic [15:0] dataOe;
    } sapc_bus_t;
endpackage

//--- test/sapc_comparator.sv
// Behavioural comparator standing for the analog front end
`timescale 1ns/1ps
`default_nettype none
module sapc_comparator (
    input  wire logic [15:0] target,
    input  wire logic [15:0] trialCode,
    output logic             compareHigh
);
    // Keeps a trial bit while the trial word does not exceed the held sample
    assign compareHigh = (trialCode <= target);
endmodule
`default_nettype wire

//--- test/testbench.sv
// Self-checking bench of the converter control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sapc_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    sapc_ctrl_t  ctrl = '{selectN: 1'b1, readConvertN: 1'b1, byteSwap: 1'b0};
    logic        compareHigh;
    logic        sampleHold;
    logic [15:0] trialCode;
    logic        busyN;
    sapc_bus_t   bus;
    logic [15:0] target = 16'h0000;
    int          fail_count = 0;
    int          n_compared = 0;

    always #50 clk = ~clk;

    sapc_control dut (.clk(clk), .rst(rst), .ctrl(ctrl), .compareHigh(compareHigh),
        .sampleHold(sampleHold), .trialCode(trialCode), .busyN(busyN), .bus(bus));
    sapc_comparator front (.target(target), .trialCode(trialCode), .compareHigh(compareHigh));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One conversion started by select or by read/convert, optional retry mid-run
    task automatic convert(input logic [15:0] value, input logic viaSelect, input logic retry);
        int lowCycles;
        lowCycles = 0;
        target = value;
        ctrl.selectN = viaSelect;
        ctrl.readConvertN = !viaSelect;
        step(1);
        ctrl.selectN = 1'b0;
        ctrl.readConvertN = 1'b0;
        for (int i = 0; i < 40; i++) begin
            step(1);
            if (busyN === 1'b0) begin
                lowCycles++;
            end else if (lowCycles > 0) begin
                break;
            end
            if (lowCycles == 1) begin
                check({15'h0, sampleHold}, 16'h0001);
                check(bus.dataOe, 16'h0000);
            end
            if (lowCycles == 2 || (retry && lowCycles == 6)) begin
                ctrl.readConvertN = 1'b1;
                ctrl.selectN = viaSelect;
            end
            if (retry && lowCycles == 4) begin
                ctrl.readConvertN = 1'b0;
                ctrl.selectN = 1'b0;
            end
        end
        check(16'(lowCycles), 16'd24);
        ctrl.selectN = 1'b0;
        #1;
        check(bus.dataOe, 16'hFFFF);
        check(bus.dataOut, value);
        ctrl.byteSwap = 1'b1;
        #1;
        check(bus.dataOut, {value[7:0], value[15:8]});
        ctrl.byteSwap = 1'b0;
        ctrl.selectN = 1'b1;
        #1;
        check(bus.dataOe, 16'h0000);
        step(15);
    endtask

    initial begin
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        check({15'h0, busyN}, 16'h0001);
        check(bus.dataOe, 16'h0000);
        convert(16'hA5C3, 1'b0, 1'b1);
        convert(16'h1234, 1'b1, 1'b1);
        convert(16'h8001, 1'b1, 1'b0);
        convert(16'h7FFE, 1'b0, 1'b0);
        close_out();
    end

    initial begin
        #100000;
        fail_count++;
        close_out();
    end
endmodule
`default_nettype wire
